/* File: src/nir_pkg.sv */
// Overview of operation
// - after status poll 70h host issues 00h to resume data output
// - host never sends per-die status 78h during parameter-page busy or output
// - random data read 05h then e0h moves the output column
// - host checks crc of first copy, moves to next copy on mismatch
// - host xors halves of a unique copy, accepts only all ffh
package nir_pkg;
  localparam logic [7:0] CMD_ID      = 8'h90;
  localparam logic [7:0] CMD_PARAM   = 8'hec;
  localparam logic [7:0] CMD_UID     = 8'hed;
  localparam logic [7:0] CMD_STATUS  = 8'h70;
  localparam logic [7:0] CMD_READ    = 8'h00;
  localparam logic [7:0] CMD_RND1    = 8'h05;
  localparam logic [7:0] CMD_RND2    = 8'he0;
  localparam logic [7:0] ADDR_ID0    = 8'h00;
  localparam logic [7:0] ADDR_ID20   = 8'h20;
  localparam logic [7:0] ADDR_PAGE   = 8'h00;
  localparam logic [7:0] ST_RDY_BIT  = 8'h40;
  localparam logic [7:0] XOR_OK      = 8'hff;
  localparam logic [7:0] EXP_B2      = 8'h90;
  localparam logic [7:0] EXP_B3      = 8'h15;
  localparam logic [7:0] EXP_B4      = 8'h06;
  localparam logic [7:0] SIG0        = 8'h4f;
  localparam logic [7:0] SIG1        = 8'h4e;
  localparam logic [7:0] SIG2        = 8'h46;
  localparam logic [7:0] SIG3        = 8'h49;
  localparam int         ID00_LEN    = 5;
  localparam int         ID20_LEN    = 4;
  localparam int         PAGE_LEN    = 256;
  localparam int         PAGE_COPIES = 3;
  localparam int         UID_LEN     = 32;
  localparam int         UID_HALF    = 16;
  localparam int         UID_COPIES  = 16;
  localparam logic [15:0] CRC_INIT   = 16'h4f4e;
  localparam logic [15:0] CRC_POLY   = 16'h8005;
  // timing in ns, counts in 5 ns cycles
  localparam int         CLK_NS      = 5;
  localparam int         T_STROBE_NS = 15;
  localparam int         T_WHR_NS    = 80;
  localparam int         STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int         WHR_CYC     = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
  // register map, byte addresses
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_STAT      = 8'h04;
  localparam logic [7:0] A_ID0       = 8'h08;
  localparam logic [7:0] A_ID1       = 8'h0c;
  localparam logic [7:0] A_MEM       = 8'h10;
  localparam logic [7:0] A_ADDR      = 8'h14;
  // ctrl fields
  localparam int         C_GO        = 0;
  localparam int         C_OP_LO     = 1;
  localparam int         C_POLL      = 3;
  localparam int         C_RND       = 4;
  typedef enum logic [1:0] {OP_ID00, OP_ID20, OP_PARAM, OP_UID} nir_op_t;
  // bus cycle kinds for the pin engine
  typedef enum logic [1:0] {CY_CMD, CY_ADDR, CY_READ} nir_cy_t;
endpackage : nir_pkg

/* File: src/nir_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module nir_mem (
  input  wire logic       i_mclk,
  input  wire logic       i_we,
  input  wire logic [8:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [8:0] i_raddr,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [0:511];
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : nir_mem
`default_nettype wire

/* File: src/nir_pins.sv */
`timescale 1ns/100ps
`default_nettype none
module nir_pins
  import nir_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_go,
  input  wire nir_cy_t    i_kind,
  input  wire logic [7:0] i_byte,
  input  wire logic [7:0] i_io_in,
  output logic            o_done,
  output logic      [7:0] o_rdata,
  output logic            o_cle,
  output logic            o_ale,
  output logic            o_write_strobe_n,
  output logic            o_read_strobe_n,
  output logic      [7:0] o_io_out,
  output logic            o_io_oe
);
  typedef enum logic [1:0] {P_IDLE, P_LOW, P_HIGH} nir_pst_t;
  nir_pst_t   st, next_st;
  logic [4:0] cnt, next_cnt;
  nir_cy_t    kind, next_kind;
  logic [7:0] rdata, next_rdata;
  logic [7:0] obyte, next_obyte;
  always_comb begin
    next_st    = st;
    next_cnt   = cnt;
    next_kind  = kind;
    next_rdata = rdata;
    next_obyte = obyte;
    o_done     = 1'b0;
    case (st)
      P_IDLE: begin
        if (i_go) begin
          next_kind  = i_kind;
          next_obyte = i_byte;
          next_cnt   = 5'(STROBE_CYC);
          next_st    = P_LOW;
        end
      end
      P_LOW: begin
        if (cnt == 5'd1) begin
          next_cnt = 5'(STROBE_CYC);
          next_st  = P_HIGH;
          if (kind == CY_READ) begin
            next_rdata = i_io_in;
          end
        end else begin
          next_cnt = cnt - 5'd1;
        end
      end
      P_HIGH: begin
        if (cnt == 5'd1) begin
          o_done  = 1'b1;
          next_st = P_IDLE;
        end else begin
          next_cnt = cnt - 5'd1;
        end
      end
      default: next_st = P_IDLE;
    endcase
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st    <= P_IDLE;
      cnt   <= '0;
      kind  <= CY_CMD;
      rdata <= '0;
      obyte <= '0;
    end else begin
      st    <= next_st;
      cnt   <= next_cnt;
      kind  <= next_kind;
      rdata <= next_rdata;
      obyte <= next_obyte;
    end
  end
  assign o_rdata          = rdata;
  assign o_cle            = (st != P_IDLE) && (kind == CY_CMD);
  assign o_ale            = (st != P_IDLE) && (kind == CY_ADDR);
  assign o_write_strobe_n = !((st == P_LOW) && (kind != CY_READ));
  assign o_read_strobe_n  = !((st == P_LOW) && (kind == CY_READ));
  assign o_io_out         = obyte;
  assign o_io_oe          = (st != P_IDLE) && (kind != CY_READ);
  one_read_per_toggle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $fell(o_read_strobe_n) |-> ##STROBE_CYC $rose(o_read_strobe_n))
    else $error("read strobe low time wrong");
endmodule : nir_pins
`default_nettype wire

/* File: src/nir_host.sv */
`timescale 1ns/100ps
`default_nettype none
module nir_host
  import nir_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_ready_busy_n,
  input  wire logic [7:0]  i_io_in,
  output logic      [7:0]  o_io_out,
  output logic             o_io_oe,
  output logic             o_cle,
  output logic             o_ale,
  output logic             o_chip_enable_n,
  output logic             o_write_strobe_n,
  output logic             o_read_strobe_n
);
  import nir_pkg::*;
  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADR, S_WHR, S_BUSY, S_POLL_CMD, S_POLL_RD, S_RESUME,
    S_RND1, S_RA0, S_RA1, S_RND2, S_READ, S_CHECK, S_DONE
  } nir_hst_t;
  nir_hst_t   st, next_st;
  nir_op_t    op, next_op;
  logic       poll, next_poll;
  logic       rnd, next_rnd;
  logic [9:0] idx, next_idx;
  logic [9:0] len, next_len;
  logic [9:0] rbase, next_rbase;
  logic [7:0] wait_cnt, next_wait_cnt;
  logic [15:0] crc, next_crc;
  logic       ok, next_ok;
  logic       err, next_err;
  logic [4:0] copy, next_copy;
  logic       pin_go;
  nir_cy_t    pin_kind;
  logic [7:0] pin_byte;
  logic       pin_done;
  logic [7:0] pin_rdata;
  logic       mem_we;
  logic [8:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [7:0] lo_byte;
  logic       acc_wr;
  nir_op_t    reg_op;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 7; b >= 0; b--) begin
      r = (r[15] ^ d[b]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step
  function automatic logic [9:0] op_len(input nir_op_t o);
    case (o)
      OP_ID00:  op_len = 10'(ID00_LEN);
      OP_ID20:  op_len = 10'(ID20_LEN);
      OP_PARAM: op_len = 10'(PAGE_LEN);
      default:  op_len = 10'(UID_LEN);
    endcase
  endfunction : op_len
  function automatic logic [7:0] op_cmd(input nir_op_t o);
    case (o)
      OP_PARAM: op_cmd = CMD_PARAM;
      OP_UID:   op_cmd = CMD_UID;
      default:  op_cmd = CMD_ID;
    endcase
  endfunction : op_cmd
  nir_pins u_pins (
    .i_mclk           (i_mclk),
    .i_rst_n          (i_rst_n),
    .i_go             (pin_go),
    .i_kind           (pin_kind),
    .i_byte           (pin_byte),
    .i_io_in          (i_io_in),
    .o_done           (pin_done),
    .o_rdata          (pin_rdata),
    .o_cle            (o_cle),
    .o_ale            (o_ale),
    .o_write_strobe_n (o_write_strobe_n),
    .o_read_strobe_n  (o_read_strobe_n),
    .o_io_out         (o_io_out),
    .o_io_oe          (o_io_oe)
  );
  nir_mem u_mem (
    .i_mclk  (i_mclk),
    .i_we    (mem_we),
    .i_waddr (idx[8:0]),
    .i_wdata (pin_rdata),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  );
  assign acc_wr  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr inside {A_CTRL, A_STAT, A_ID0, A_ID1, A_MEM, A_ADDR});
  assign mem_we  = (st == S_READ) && pin_done;
  assign reg_op  = nir_op_t'(pwdata[C_OP_LO +: 2]);
  assign o_chip_enable_n = (st == S_IDLE) || (st == S_DONE);
  always_comb begin
    next_st = st;
    next_op = op;
    next_poll = poll;
    next_rnd = rnd;
    next_idx = idx;
    next_len = len;
    next_rbase = rbase;
    next_wait_cnt = wait_cnt;
    next_crc = crc;
    next_ok = ok;
    next_err = err;
    next_copy = copy;
    pin_go = 1'b0;
    pin_kind = CY_CMD;
    pin_byte = 8'h00;
    lo_byte = 8'h00;
    if (acc_wr && paddr == A_ADDR) begin
      next_rbase = pwdata[9:0];
    end
    case (st)
      S_IDLE, S_DONE: begin
        if (acc_wr && paddr == A_CTRL && pwdata[C_GO] && i_ready_busy_n) begin
          next_op = reg_op;
          next_poll = pwdata[C_POLL];
          next_rnd = pwdata[C_RND] && (reg_op inside {OP_PARAM, OP_UID});
          next_len = op_len(reg_op);
          next_idx = '0;
          next_crc = CRC_INIT;
          next_ok = 1'b1;
          next_err = 1'b0;
          next_copy = '0;
          next_st = S_CMD;
        end
      end
      S_CMD: begin
        pin_go = 1'b1;
        pin_byte = op_cmd(op);
        if (pin_done) next_st = S_ADR;
      end
      S_ADR: begin
        pin_go = 1'b1;
        pin_kind = CY_ADDR;
        pin_byte = (op == OP_ID20) ? ADDR_ID20 : ADDR_ID0;
        if (pin_done) begin
          next_wait_cnt = 8'(WHR_CYC);
          next_st = S_WHR;
        end
      end
      S_WHR: begin
        if (wait_cnt == 8'd0) begin
          next_st = (op inside {OP_PARAM, OP_UID}) ? S_BUSY : S_READ;
        end else begin
          next_wait_cnt = wait_cnt - 8'd1;
        end
      end
      S_BUSY: begin
        if (poll) begin
          next_st = S_POLL_CMD;
        end else if (i_ready_busy_n) begin
          next_st = rnd ? S_RND1 : S_READ;
        end
      end
      S_POLL_CMD: begin
        pin_go = 1'b1;
        pin_byte = CMD_STATUS;
        if (pin_done) next_st = S_POLL_RD;
      end
      S_POLL_RD: begin
        pin_go = 1'b1;
        pin_kind = CY_READ;
        if (pin_done) next_st = ((pin_rdata & ST_RDY_BIT) != 8'h00) ? S_RESUME : S_POLL_RD;
      end
      S_RESUME: begin
        pin_go = 1'b1;
        pin_byte = CMD_READ;
        if (pin_done) next_st = rnd ? S_RND1 : S_READ;
      end
      S_RND1: begin
        pin_go = 1'b1;
        pin_byte = CMD_RND1;
        if (pin_done) next_st = S_RA0;
      end
      S_RA0: begin
        pin_go = 1'b1;
        pin_kind = CY_ADDR;
        pin_byte = rbase[7:0];
        if (pin_done) next_st = S_RA1;
      end
      S_RA1: begin
        pin_go = 1'b1;
        pin_kind = CY_ADDR;
        pin_byte = {6'h00, rbase[9:8]};
        if (pin_done) next_st = S_RND2;
      end
      S_RND2: begin
        pin_go = 1'b1;
        pin_byte = CMD_RND2;
        if (pin_done) begin
          next_wait_cnt = 8'(WHR_CYC);
          next_rnd = 1'b0;
          next_st = S_WHR;
        end
      end
      S_READ: begin
        pin_go = 1'b1;
        pin_kind = CY_READ;
        if (pin_done) begin
          if (op == OP_PARAM && idx < 10'(PAGE_LEN - 2)) begin
            next_crc = crc_step(crc, pin_rdata);
          end
          if (op == OP_PARAM && idx == 10'(PAGE_LEN - 2)) begin
            next_ok = ok && (pin_rdata == crc[7:0]);
          end
          if (op == OP_PARAM && idx == 10'(PAGE_LEN - 1)) begin
            next_ok = ok && (pin_rdata == crc[15:8]);
          end
          next_idx = idx + 10'd1;
          if (idx == len - 10'd1) begin
            next_st = (op == OP_UID) ? S_CHECK : S_DONE;
            next_idx = '0;
            if (op == OP_PARAM && !next_ok && copy < 5'(PAGE_COPIES - 1)) begin
              next_copy = copy + 5'd1;
              next_crc = CRC_INIT;
              next_ok = 1'b1;
              next_st = S_READ;
            end
            if (op == OP_PARAM && !next_ok && copy == 5'(PAGE_COPIES - 1)) next_err = 1'b1;
          end
        end
      end
      S_CHECK: begin
        lo_byte = mem_rdata;
        next_idx = idx + 10'd1;
        if (idx >= 10'd2 && idx[0] == 1'b0) begin
          next_ok = ok && ((crc[7:0] ^ mem_rdata) == XOR_OK);
        end
        next_crc = {8'h00, lo_byte};
        if (idx == 10'(2 * UID_HALF)) begin
          next_idx = '0;
          if (!next_ok && copy < 5'(UID_COPIES - 1)) begin
            next_copy = copy + 5'd1;
            next_ok = 1'b1;
            next_st = S_READ;
          end else begin
            next_err = !next_ok;
            next_st = S_DONE;
          end
        end
      end
      default: next_st = S_IDLE;
    endcase
  end
  // check pass pairs byte i with i+16 through the memory read port
  always_comb begin
    mem_raddr = rbase[8:0];
    if (st == S_CHECK) begin
      mem_raddr = (idx[0] == 1'b0) ? 9'(idx >> 1) : 9'((idx >> 1) + 10'(UID_HALF));
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= S_IDLE;
      op <= OP_ID00;
      poll <= 1'b0;
      rnd <= 1'b0;
      idx <= '0;
      len <= '0;
      rbase <= '0;
      wait_cnt <= '0;
      crc <= '0;
      ok <= 1'b0;
      err <= 1'b0;
      copy <= '0;
    end else begin
      st <= next_st;
      op <= next_op;
      poll <= next_poll;
      rnd <= next_rnd;
      idx <= next_idx;
      len <= next_len;
      rbase <= next_rbase;
      wait_cnt <= next_wait_cnt;
      crc <= next_crc;
      ok <= next_ok;
      err <= next_err;
      copy <= next_copy;
    end
  end
  // id snapshot of the first five bytes
  logic [39:0] id_bytes, next_id_bytes;
  always_comb begin
    next_id_bytes = id_bytes;
    if (mem_we && op inside {OP_ID00, OP_ID20} && idx < 10'(ID00_LEN)) begin
      next_id_bytes[idx[2:0]*8 +: 8] = pin_rdata;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) id_bytes <= '0;
    else id_bytes <= next_id_bytes;
  end
  logic id_match;
  assign id_match = (op == OP_ID00) ?
    (id_bytes[23:16] == EXP_B2 && id_bytes[31:24] == EXP_B3 && id_bytes[39:32] == EXP_B4) :
    (id_bytes[7:0] == SIG0 && id_bytes[15:8] == SIG1 && id_bytes[23:16] == SIG2 &&
     id_bytes[31:24] == SIG3);
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      A_STAT:  prdata = {16'h0000, 3'h0, copy, 4'h0, id_match, err, ok, st == S_DONE};
      A_ID0:   prdata = id_bytes[31:0];
      A_ID1:   prdata = {24'h000000, id_bytes[39:32]};
      A_MEM:   prdata = {24'h000000, mem_rdata};
      A_ADDR:  prdata = {22'h0, rbase};
      default: prdata = 32'h0000_0000;
    endcase
  end
  no_78_cmd_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_cle && o_io_oe) |-> o_io_out != 8'h78)
    else $error("per-die status command issued");
  idle_start_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st inside {S_IDLE, S_DONE} && next_st == S_CMD) |-> i_ready_busy_n)
    else $error("command started while busy");
  sequence read_mode_cmd_s;
    o_cle && o_io_oe && (o_io_out == CMD_READ);
  endsequence
  resume_after_poll_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st == S_POLL_RD && next_st == S_RESUME) |=> ##[0:2] read_mode_cmd_s)
    else $error("no read mode after status poll");
  read_when_ready_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st == S_READ && !o_read_strobe_n) |-> i_ready_busy_n)
    else $error("data read while target busy");
endmodule : nir_host
`default_nettype wire

/* File: sim/nir_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nir_flash_model
  import nir_pkg::*;
#(
  parameter logic [7:0] MAKER  = 8'h1b, // arbitrary
  parameter logic [7:0] DEVICE = 8'h7e, // arbitrary
  parameter int         T_R    = 400
) (
  input  wire logic        i_mclk,
  input  wire logic        i_ce_n,
  input  wire logic        i_cle,
  input  wire logic        i_ale,
  input  wire logic        i_we_n,
  input  wire logic        i_re_n,
  input  wire logic [7:0]  i_io,
  input  wire logic        i_bad_param,
  input  wire logic        i_bad_uid,
  output logic      [7:0]  o_io,
  output logic             o_rb_n,
  output logic      [7:0]  o_cmd_cnt,
  output logic      [15:0] o_last_col,
  output logic             o_resumed
);
  logic [7:0]  cmd, dout;
  logic [15:0] crc, col;
  logic [12:0] ptr;
  logic [1:0]  mode;
  logic        stat, we_q, re_q, drv, tgl;
  int          busy, nadr;
  logic [7:0]  sig [4] = '{8'h4f, 8'h4e, 8'h46, 8'h49};

  function automatic logic [7:0] pbyte(input int c);
    return (c < 4) ? sig[c] : (8'(c) ^ 8'h5a);
  endfunction : pbyte

  function automatic logic [7:0] byte_at(input logic [12:0] p);
    int         c;
    logic [7:0] v;
    case (mode)
      2'd0: v = (p == 0) ? MAKER : (p == 1) ? DEVICE : (p == 2) ? 8'h90 :
                (p == 3) ? 8'h15 : 8'h06;
      2'd1: v = (p < 4) ? sig[p] : (8'ha5 ^ p[7:0]);
      2'd2: begin
        c = p % 256;
        v = (c == 254) ? crc[7:0] : (c == 255) ? crc[15:8] : pbyte(c);
        if (i_bad_param && p < 256 && c == 10) v = ~v;
      end
      default: begin
        c = p % 32;
        v = {p[8:5], 4'(c % 16)} ^ 8'h3c;
        if (c >= 16) v = ~v;
        if (i_bad_uid && p < 32 && c == 16) v = ~v;
      end
    endcase
    return v;
  endfunction : byte_at

  initial begin
    logic [7:0] pb;
    we_q = 1'b1; re_q = 1'b1; drv = 1'b0; tgl = 1'b0; busy = 0; stat = 1'b0;
    o_cmd_cnt = 8'h00; o_resumed = 1'b0; o_last_col = 16'h0000; cmd = 8'hff;
    mode = 2'd0; ptr = '0; dout = 8'h00; col = 16'h0000; nadr = 0;
    crc = CRC_INIT;
    for (int i = 0; i < 254; i++) begin
      pb = pbyte(i);
      for (int j = 7; j >= 0; j--) begin
        if (crc[15] ^ pb[j]) crc = {crc[14:0], 1'b0} ^ CRC_POLY;
        else crc = {crc[14:0], 1'b0};
      end
    end
  end

  always @(posedge i_mclk) begin
    we_q <= i_we_n;
    re_q <= i_re_n;
    tgl  <= ~tgl;
    if (busy > 0) busy <= busy - 1;
    if (i_ce_n) drv <= 1'b0;
    else if (!we_q && i_we_n && i_cle) begin
      if (i_io == 8'hec || i_io == 8'hed) begin
        if (busy == 0) begin
          cmd <= i_io;
          stat <= 1'b0;
          mode <= (i_io == 8'hec) ? 2'd2 : 2'd3;
          o_cmd_cnt <= o_cmd_cnt + 8'h01;
        end
      end else begin
        cmd <= i_io;
        if (i_io == 8'h70) stat <= 1'b1;
        if (i_io == 8'h00) begin
          o_resumed <= stat;
          stat <= 1'b0;
        end
        if (i_io == 8'h05) nadr <= 0;
        if (i_io == 8'he0) begin
          ptr <= col[12:0];
          o_last_col <= col;
        end
      end
    end else if (!we_q && i_we_n && i_ale) begin
      if (cmd == 8'h90) begin
        mode <= (i_io == 8'h20) ? 2'd1 : 2'd0;
        ptr <= '0;
      end else if ((cmd == 8'hec || cmd == 8'hed) && i_io == 8'h00) begin
        busy <= T_R;
        ptr <= '0;
      end else if (cmd == 8'h05) begin
        if (nadr == 0) col[7:0] <= i_io;
        else col[15:8] <= i_io;
        nadr <= nadr + 1;
      end
    end else if (re_q && !i_re_n && !i_cle && !i_ale && (stat || busy == 0)) begin
      dout <= stat ? ((busy == 0) ? 8'h40 : 8'h00) : byte_at(ptr);
      if (!stat) ptr <= ptr + 13'd1;
      drv <= 1'b1;
    end
  end

  assign o_rb_n = (busy == 0);
  assign o_io   = drv ? dout : (~dout ^ {8{tgl}});
endmodule : nir_flash_model
`default_nettype wire

/* File: sim/nir_host_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module nir_host_tb;
  import nir_pkg::*;
  localparam logic [7:0] MAK = 8'h1b; // arbitrary
  localparam logic [7:0] DEV = 8'h7e; // arbitrary
  logic        i_mclk, i_rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, io_out, dev_io, bus, cmd_cnt, c0;
  logic [31:0] pwdata, prdata, rd;
  logic        rb_n, io_oe, cle, ale, ce_n, we_n, re_n, bad_p, bad_u, resumed, err;
  logic [15:0] last_col;
  int          fails, n_checks;
  logic        saw_78 = 1'b0;

  always @(posedge i_mclk) begin
    if (!ce_n && cle && !we_n && bus == 8'h78) saw_78 <= 1'b1;
  end

  assign bus = io_oe ? io_out : dev_io;

  nir_host nir_host_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_ready_busy_n(rb_n), .i_io_in(bus), .o_io_out(io_out), .o_io_oe(io_oe),
    .o_cle(cle), .o_ale(ale), .o_chip_enable_n(ce_n), .o_write_strobe_n(we_n),
    .o_read_strobe_n(re_n)
  );

  nir_flash_model #(.MAKER(MAK), .DEVICE(DEV), .T_R(400)) nir_flash_model_i (
    .i_mclk(i_mclk), .i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n),
    .i_re_n(re_n), .i_io(bus), .i_bad_param(bad_p), .i_bad_uid(bad_u), .o_io(dev_io),
    .o_rb_n(rb_n), .o_cmd_cnt(cmd_cnt), .o_last_col(last_col), .o_resumed(resumed)
  );

  task automatic report_and_stop;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    @(posedge i_mclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic run(input logic [31:0] ctrl);
    int n;
    apb(1'b1, A_CTRL, ctrl);
    n = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      fails++;
      report_and_stop();
    end
  endtask : run

  task automatic mem(input logic [31:0] a);
    apb(1'b1, A_ADDR, a);
    apb(1'b0, A_MEM, 32'h0);
    apb(1'b0, A_MEM, 32'h0);
  endtask : mem

  task automatic t_reset;
    apb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(err), 32'h1);
  endtask : t_reset

  task automatic t_ids;
    run(32'h1);
    chk(rd & 32'hd, 32'h9);
    apb(1'b0, A_ID0, 32'h0);
    chk(rd, {8'h15, 8'h90, DEV, MAK});
    apb(1'b0, A_ID1, 32'h0);
    chk(32'(rd[7:0]), 32'h06);
    run(32'h3);
    chk(rd & 32'hd, 32'h9);
    apb(1'b0, A_ID0, 32'h0);
    chk(rd, 32'h49464e4f);
  endtask : t_ids

  task automatic t_param;
    bad_p <= 1'b1;
    run(32'h5);
    chk(rd & 32'h1f07, 32'h0103);
    mem(32'h0);
    chk(32'(rd[7:0]), 32'h4f);
    mem(32'ha);
    chk(32'(rd[7:0]), 32'h50);
    bad_p <= 1'b0;
  endtask : t_param

  task automatic t_uid_poll;
    bad_u <= 1'b1;
    c0 = cmd_cnt;
    run(32'hf);
    chk(rd & 32'h1f07, 32'h0103);
    chk(32'(resumed), 32'h1);
    chk(32'(cmd_cnt), 32'(c0) + 1);
    mem(32'h0);
    chk(32'(rd[7:0]), 32'h2c);
    mem(32'h10);
    chk(32'(rd[7:0]), 32'hd3);
    bad_u <= 1'b0;
  endtask : t_uid_poll

  task automatic t_refuse;
    c0 = cmd_cnt;
    apb(1'b1, A_CTRL, 32'h5);
    repeat (20) @(posedge i_mclk);
    run(32'h7);
    chk(32'(cmd_cnt), 32'(c0) + 1);
    chk(rd & 32'h1f07, 32'h0003);
  endtask : t_refuse

  task automatic t_rnd;
    apb(1'b1, A_ADDR, 32'h100);
    run(32'h15);
    chk(32'(last_col[8:0]), 32'h100);
    chk(rd & 32'h2, 32'h2);
    chk(32'(saw_78), 32'h0);
  endtask : t_rnd

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  initial begin
    fails = 0; n_checks = 0; i_rst_n = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; bad_p = 1'b0; bad_u = 1'b0;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_reset();
    t_ids();
    t_param();
    t_uid_poll();
    t_refuse();
    t_rnd();
    report_and_stop();
  end
endmodule : nir_host_tb
`default_nettype wire
